/* zds_pkg.sv */
// zds_pkg: constants, states and shared decoding for the zoom decimation/sync block
// assumes: a 32-bit APB register bus on pclk; sample strobes synchronous to pclk
package zds_pkg;

   // register byte offsets
   localparam logic [7:0] ZDS_OFF_CTRL   = 8'h00;
   localparam logic [7:0] ZDS_OFF_COARSE = 8'h04;
   localparam logic [7:0] ZDS_OFF_FINE   = 8'h08;
   localparam logic [7:0] ZDS_OFF_CMD    = 8'h0c;
   localparam logic [7:0] ZDS_OFF_STATUS = 8'h10;

   // control register fields
   localparam int ZDS_CTRL_BW_LSB   = 0;
   localparam int ZDS_BW_W          = 5;
   localparam int ZDS_CTRL_DEC_BIT  = 8;
   localparam int ZDS_CTRL_CDC_BIT  = 9;
   localparam int ZDS_CTRL_DEFR_BIT = 10;
   localparam int ZDS_CTRL_R32_BIT  = 12;
   localparam int ZDS_CTRL_CPX_BIT  = 13;
   localparam int ZDS_CTRL_CONT_BIT = 14;

   // command register bits (write-one actions)
   localparam int ZDS_CMD_ALIGN_BIT = 0;
   localparam int ZDS_CMD_IDLE_BIT  = 1;
   localparam int ZDS_CMD_START_BIT = 2;

   // status register fields
   localparam int ZDS_ST_STATE_LSB = 0;
   localparam int ZDS_ST_PEND_BIT  = 3;
   localparam int ZDS_ST_SETL_BIT  = 4;
   localparam int ZDS_ST_BLK_BIT   = 5;
   localparam int ZDS_ST_CONT_BIT  = 6;
   localparam int ZDS_ST_SYNC_BIT  = 7;
   localparam int ZDS_ST_RATE_LSB  = 8;

   // limits and widths
   localparam logic [4:0] ZDS_BW_MAX      = 5'h18;
   localparam int         ZDS_COARSE_W    = 11;
   localparam int         ZDS_FINE_W      = 29;
   localparam logic [28:0] ZDS_FINE_MAX   = 29'h1dcd64ff;
   localparam logic [29:0] ZDS_FINE_MOD   = 30'h1dcd6500;
   localparam int         ZDS_STAGES      = 24;
   localparam logic [5:0] ZDS_SETTLE_OUT  = 6'h1e;

   typedef enum logic [2:0] {
      ZDS_IDLE       = 3'b000,
      ZDS_ALIGN_WAIT = 3'b001,
      ZDS_ALIGNED    = 3'b010,
      ZDS_ARMED      = 3'b011,
      ZDS_MEASURE    = 3'b100
   } zds_state_e;

   // log2 of converter rate over output rate
   function automatic logic [4:0] zds_rate_log2(input logic [4:0] bw, input logic dec);
      logic [4:0] base;
      base = (bw <= 5'h01) ? 5'h00 : 5'(bw - 5'h01);
      return 5'(base + {4'h0, dec});
   endfunction

endpackage

/* zds_dec_if.sv */
// zds_dec_if: signals between the control top and its counter and sync leaves
// assumes: all members on pclk except sync_raw, which carries the asynchronous sync line
`timescale 1ns/1ps
`default_nettype none
interface zds_dec_if;
   logic [4:0] bw;
   logic       dec;
   logic       sample_valid;
   logic       align_now;
   logic       out_keep;
   logic       settling;
   logic       sync_raw;
   logic       sync_rise;
   modport ctl  (output bw, dec, sample_valid, align_now, sync_raw,
                 input out_keep, settling, sync_rise);
   modport cnt  (input bw, dec, sample_valid, align_now, output out_keep, settling);
   modport edge_det (input sync_raw, output sync_rise);
endinterface
`default_nettype wire

/* zds_sync_edge.sv */
// zds_sync_edge: two-flop synchroniser and registered rise detect of the sync line
// assumes: sync line asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module zds_sync_edge
   import zds_pkg::*;
(
   // clock and reset
   input wire logic  pclk,
   input wire logic  presetn,
   // sync line
   zds_dec_if.edge_det e
);
   logic meta_r;
   logic sync_r;
   logic prev_r;
   logic rise_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= e.sync_raw;
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         prev_r <= sync_r;
         rise_r <= sync_r & ~prev_r;
      end
   end

   assign e.sync_rise = rise_r;
endmodule
`default_nettype wire

/* zds_decim_counter.sv */
// zds_decim_counter: decimation counter, per-stage keep strobes, settle count
// assumes: one sample_valid pulse per converter sample
`timescale 1ns/1ps
`default_nettype none
module zds_decim_counter
   import zds_pkg::*;
(
   // clock and reset
   input wire logic  pclk,
   input wire logic  presetn,
   // control side
   zds_dec_if.cnt    d
);
   logic [ZDS_STAGES-1:0] cnt_r;
   logic [ZDS_STAGES-1:0] stage_keep;
   logic [5:0]            settle_r;
   logic [4:0]            rl;

   // stage gi keeps one sample in 2^(gi+1)
   genvar gi;
   generate
      for (gi = 0; gi < ZDS_STAGES; gi++) begin : g_stage
         assign stage_keep[gi] = (cnt_r[gi:0] == '0);
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
      end else if (d.align_now) begin
         cnt_r <= '0;
      end else if (d.sample_valid) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_comb begin
      rl = zds_rate_log2(d.bw, d.dec);
      if (!d.sample_valid || d.align_now) begin
         d.out_keep = 1'b0;
      end else if (rl == 5'h00) begin
         d.out_keep = 1'b1;
      end else begin
         d.out_keep = stage_keep[rl - 5'h01];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_r <= 6'h00;
      end else if (d.align_now) begin
         settle_r <= ZDS_SETTLE_OUT;
      end else if (d.out_keep && settle_r != 6'h00) begin
         settle_r <= settle_r - 6'h01;
      end
   end

   assign d.settling = (settle_r != 6'h00);
endmodule
`default_nettype wire

/* zds_zoom_ctrl.sv */
// zds_zoom_ctrl: APB control of decimation alignment and the zoom oscillator
// assumes: APB master on pclk; samples and sync line as described in the ports
`timescale 1ns/1ps
`default_nettype none

module zds_zoom_ctrl
   import zds_pkg::*;
(
   // clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // converter samples and sync line
   input  wire logic                    sample_valid,
   input  wire logic                    sync_in,
   // results
   output logic                         out_valid,
   output logic      [ZDS_COARSE_W-1:0] lo_phase,
   output logic                         spectral_invert,
   output logic                         settling,
   output logic                         meas_active,
   output logic                         trigger_allowed
);
   zds_dec_if dif ();

   zds_state_e            state_r;
   logic [4:0]            bw_r;
   logic                  dec_r;
   logic                  cdc_r;
   logic                  defer_r;
   logic                  r32_r;
   logic                  cpx_r;
   logic                  cont_r;
   logic [ZDS_COARSE_W-1:0] pend_coarse_r;
   logic [ZDS_FINE_W-1:0]   pend_fine_r;
   logic                  pend_r;
   logic [ZDS_COARSE_W-1:0] act_coarse_r;
   logic [ZDS_FINE_W-1:0]   act_fine_r;
   logic [ZDS_COARSE_W-1:0] acc_coarse_r;
   logic [ZDS_FINE_W-1:0]   acc_fine_r;
   logic [31:0]           prdata_r;
   logic                  pready_r;
   logic                  pslverr_r;
   logic                  out_valid_r;
   logic                  settling_r;
   logic                  meas_r;
   logic                  trig_r;

   logic                  setup_ph;
   logic                  wr_ok;
   logic                  wr_bad;
   logic [1:0]            cap_ok;
   logic                  apply;
   logic                  zero_tgt;
   logic [29:0]           fine_sum;
   logic                  carry;
   logic [31:0]           status;

   // block / continuous permission per data format
   function automatic logic [1:0] zds_cap_ok(input logic r32, input logic cpx,
                                             input logic dec, input logic [4:0] bw);
      logic low;
      low = (bw <= 5'h01);
      if (!r32 && cpx && !dec && low) begin
         return 2'b01;
      end else if (r32 && !cpx && !dec && low) begin
         return 2'b01;
      end else if (r32 && cpx && dec && low) begin
         return 2'b01;
      end else if (r32 && cpx && !dec && bw == 5'h02) begin
         return 2'b01;
      end else if (r32 && cpx && !dec && low) begin
         return 2'b00;
      end else begin
         return 2'b11;
      end
   endfunction

   assign dif.bw           = bw_r;
   assign dif.dec          = dec_r;
   assign dif.sample_valid = sample_valid;
   assign dif.sync_raw     = sync_in;
   assign dif.align_now    = (state_r == ZDS_ALIGN_WAIT) && dif.sync_rise;

   zds_sync_edge u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .e       (dif.edge_det)
   );

   zds_decim_counter u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (dif.cnt)
   );

   // apb decode
   assign setup_ph = psel && !penable;
   assign wr_ok    = psel && penable && pready_r && pwrite && !pslverr_r;
   assign cap_ok   = zds_cap_ok(r32_r, cpx_r, dec_r, bw_r);

   always_comb begin
      wr_bad = 1'b0;
      if (pwrite && paddr == ZDS_OFF_CTRL) begin
         wr_bad = (pwdata[ZDS_CTRL_BW_LSB +: ZDS_BW_W] > ZDS_BW_MAX) ||
                  (pwdata[7:ZDS_BW_W] != 3'h0);
      end else if (pwrite && paddr == ZDS_OFF_COARSE) begin
         wr_bad = (pwdata[31:ZDS_COARSE_W] != '0);
      end else if (pwrite && paddr == ZDS_OFF_FINE) begin
         wr_bad = (pwdata[31:ZDS_FINE_W] != '0) ||
                  (pwdata[ZDS_FINE_W-1:0] > ZDS_FINE_MAX);
      end else if (pwrite && paddr == ZDS_OFF_STATUS) begin
         wr_bad = 1'b1;
      end else if (paddr != ZDS_OFF_CTRL && paddr != ZDS_OFF_COARSE &&
                   paddr != ZDS_OFF_FINE && paddr != ZDS_OFF_CMD &&
                   paddr != ZDS_OFF_STATUS) begin
         wr_bad = 1'b1;
      end
   end

   always_comb begin
      status = '0;
      status[ZDS_ST_STATE_LSB +: 3] = state_r;
      status[ZDS_ST_PEND_BIT]       = pend_r;
      status[ZDS_ST_SETL_BIT]       = settling_r;
      status[ZDS_ST_BLK_BIT]        = cap_ok[0];
      status[ZDS_ST_CONT_BIT]       = cap_ok[1];
      status[ZDS_ST_SYNC_BIT]       = (state_r == ZDS_IDLE) || (state_r == ZDS_ALIGNED) ||
                                      (state_r == ZDS_ARMED);
      status[ZDS_ST_RATE_LSB +: 5]  = zds_rate_log2(bw_r, dec_r);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= '0;
      end else begin
         pready_r  <= setup_ph;
         pslverr_r <= setup_ph && wr_bad;
         if (setup_ph && !pwrite) begin
            case (paddr)
               ZDS_OFF_CTRL: begin
                  prdata_r <= {17'h0, cont_r, cpx_r, r32_r, 1'b0, defer_r, cdc_r, dec_r,
                               3'h0, bw_r};
               end
               ZDS_OFF_COARSE: begin
                  prdata_r <= {21'h0, pend_coarse_r};
               end
               ZDS_OFF_FINE: begin
                  prdata_r <= {3'h0, pend_fine_r};
               end
               ZDS_OFF_STATUS: begin
                  prdata_r <= status;
               end
               default: begin
                  prdata_r <= '0;
               end
            endcase
         end
      end
   end

   // control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bw_r    <= '0;
         dec_r   <= 1'b0;
         cdc_r   <= 1'b0;
         defer_r <= 1'b0;
         r32_r   <= 1'b1;
         cpx_r   <= 1'b0;
         cont_r  <= 1'b0;
      end else if (wr_ok && paddr == ZDS_OFF_CTRL) begin
         bw_r    <= pwdata[ZDS_CTRL_BW_LSB +: ZDS_BW_W];
         dec_r   <= pwdata[ZDS_CTRL_DEC_BIT];
         cdc_r   <= pwdata[ZDS_CTRL_CDC_BIT];
         defer_r <= pwdata[ZDS_CTRL_DEFR_BIT];
         r32_r   <= pwdata[ZDS_CTRL_R32_BIT];
         cpx_r   <= pwdata[ZDS_CTRL_CPX_BIT];
         cont_r  <= pwdata[ZDS_CTRL_CONT_BIT];
      end
   end

   // pending frequency; a new write wins over a same-cycle apply
   assign apply    = pend_r && (!defer_r || dif.sync_rise);
   assign zero_tgt = (pend_coarse_r == '0) && (pend_fine_r == '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_coarse_r <= '0;
         pend_fine_r   <= '0;
         pend_r        <= 1'b0;
      end else if (wr_ok && paddr == ZDS_OFF_COARSE) begin
         pend_coarse_r <= pwdata[ZDS_COARSE_W-1:0];
         pend_r        <= 1'b1;
      end else if (wr_ok && paddr == ZDS_OFF_FINE) begin
         pend_fine_r   <= pwdata[ZDS_FINE_W-1:0];
         pend_r        <= 1'b1;
      end else if (apply) begin
         pend_r        <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_coarse_r <= '0;
         act_fine_r   <= '0;
      end else if (apply) begin
         act_coarse_r <= pend_coarse_r;
         act_fine_r   <= pend_fine_r;
      end
   end

   // phase: coarse in 1/2048 cycle, fine carries at its modulus
   assign fine_sum = {1'b0, acc_fine_r} + {1'b0, act_fine_r};
   assign carry    = (fine_sum >= ZDS_FINE_MOD);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_coarse_r <= '0;
         acc_fine_r   <= '0;
      end else if (apply && zero_tgt && !cdc_r) begin
         acc_coarse_r <= '0;
         acc_fine_r   <= '0;
      end else if (sample_valid) begin
         acc_coarse_r <= ZDS_COARSE_W'(acc_coarse_r + act_coarse_r + {10'h0, carry});
         acc_fine_r   <= carry ? ZDS_FINE_W'(fine_sum - ZDS_FINE_MOD)
                               : fine_sum[ZDS_FINE_W-1:0];
      end
   end

   // measurement and alignment sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ZDS_IDLE;
      end else if (wr_ok && paddr == ZDS_OFF_CMD && pwdata[ZDS_CMD_ALIGN_BIT]) begin
         state_r <= ZDS_ALIGN_WAIT;
      end else if (wr_ok && paddr == ZDS_OFF_CMD && pwdata[ZDS_CMD_IDLE_BIT]) begin
         state_r <= ZDS_IDLE;
      end else if (wr_ok && paddr == ZDS_OFF_CMD && pwdata[ZDS_CMD_START_BIT] &&
                   (state_r == ZDS_IDLE || state_r == ZDS_ARMED) &&
                   (cont_r ? cap_ok[1] : cap_ok[0])) begin
         state_r <= ZDS_MEASURE;
      end else begin
         case (state_r)
            ZDS_ALIGN_WAIT: begin
               if (dif.sync_rise) begin
                  state_r <= ZDS_ALIGNED;
               end
            end
            ZDS_ALIGNED: begin
               if (dif.sync_rise) begin
                  state_r <= ZDS_ARMED;
               end
            end
            ZDS_IDLE, ZDS_ARMED, ZDS_MEASURE: begin
               state_r <= state_r;
            end
            default: begin
               state_r <= ZDS_IDLE;
            end
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid_r <= 1'b0;
         settling_r  <= 1'b0;
         meas_r      <= 1'b0;
         trig_r      <= 1'b0;
      end else begin
         out_valid_r <= dif.out_keep;
         settling_r  <= dif.settling;
         meas_r      <= (state_r == ZDS_MEASURE);
         trig_r      <= (state_r == ZDS_ARMED);
      end
   end

   assign prdata          = prdata_r;
   assign pready          = pready_r;
   assign pslverr         = pslverr_r;
   assign out_valid       = out_valid_r;
   assign lo_phase        = acc_coarse_r;
   assign spectral_invert = act_coarse_r[ZDS_COARSE_W-1];
   assign settling        = settling_r;
   assign meas_active     = meas_r;
   assign trigger_allowed = trig_r;
endmodule
`default_nettype wire

/* zds_zoom_ctrl_properties.sv */
// zds_zoom_ctrl_properties: concurrent checks on the zoom control top ports
// assumes: bound to every zds_zoom_ctrl; one clock pclk, reset presetn
`timescale 1ns/1ps
`default_nettype none
module zds_zoom_ctrl_properties
   import zds_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // samples, sync and results
   input wire logic        sample_valid,
   input wire logic        sync_in,
   input wire logic        out_valid,
   input wire logic        settling,
   input wire logic        meas_active,
   input wire logic        trigger_allowed
);
   logic       wr;
   logic [5:0] setl_cnt_r;
   assign wr = psel && penable && pready && pwrite;
   // outputs counted while settling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) setl_cnt_r <= 6'h0;
      else if (!settling) setl_cnt_r <= 6'h0;
      else if (out_valid) setl_cnt_r <= setl_cnt_r + 6'h1;
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_keep;
      out_valid |-> $past(sample_valid);
   endproperty
   property p_align_ends;
      wr && paddr == ZDS_OFF_CMD && pwdata[0] |=> ##1 !meas_active && !trigger_allowed;
   endproperty
   property p_excl;
      !(meas_active && trigger_allowed);
   endproperty
   property p_settle_cnt;
      $fell(settling) |-> setl_cnt_r inside {6'h1d, 6'h1e};
   endproperty
   property p_settle_sync;
      $rose(settling) |-> $past(sync_in, 3);
   endproperty
   property p_arm_sync;
      $rose(trigger_allowed) |-> $past(sync_in, 3);
   endproperty
   property p_bw_keeps;
      wr && paddr == ZDS_OFF_CTRL && trigger_allowed && !settling |=> !settling;
   endproperty
   property p_coarse_rng;
      wr && paddr == ZDS_OFF_COARSE && pwdata[31:11] != 21'h0 |-> pslverr;
   endproperty
   property p_bw_rng;
      wr && paddr == ZDS_OFF_CTRL && pwdata[4:0] > ZDS_BW_MAX |-> pslverr;
   endproperty
   property p_one_access;
      pready |-> psel && penable ##1 !pready;
   endproperty
   a_keep: assert property (p_keep)
      else $error("kept output without a sample");
   a_align_ends: assert property (p_align_ends)
      else $error("measurement survives align");
   a_excl: assert property (p_excl)
      else $error("measure and armed together");
   a_settle_cnt: assert property (p_settle_cnt)
      else $error("settling length wrong");
   a_settle_sync: assert property (p_settle_sync)
      else $error("counter reset without sync");
   a_arm_sync: assert property (p_arm_sync)
      else $error("armed without sync");
   a_bw_keeps: assert property (p_bw_keeps)
      else $error("bandwidth change reset counter");
   a_coarse_rng: assert property (p_coarse_rng)
      else $error("coarse out of range accepted");
   a_bw_rng: assert property (p_bw_rng)
      else $error("bandwidth out of range accepted");
   a_one_access: assert property (p_one_access)
      else $error("ready outside one access cycle");
   c_armed: cover property ($rose(trigger_allowed));
   c_settled: cover property ($fell(settling));
   c_refused: cover property (pready && pslverr);
endmodule
bind zds_zoom_ctrl zds_zoom_ctrl_properties u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .sample_valid, .sync_in, .out_valid,
   .settling, .meas_active, .trigger_allowed);
`default_nettype wire

/* zds_far_side.sv */
// zds_far_side: converter sample strobe and sync line master
// assumes: pclk shared with the block; sync_req a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module zds_far_side
   import zds_pkg::*;
#(
   parameter int HOLD = 8
)
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // host requests
   input  wire logic slow,
   input  wire logic sync_req,
   // lines to the block
   output logic      sample_valid,
   output logic      sync_in
);
   logic [1:0] div_r;
   logic [3:0] hold_r;
   // one sample every 2 or 4 clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_r <= 2'h0;
      else div_r <= div_r + 2'h1;
   end
   assign sample_valid = slow ? (div_r == 2'h3) : div_r[0];
   // sync asserted then released
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hold_r <= 4'h0;
      else if (sync_req) hold_r <= 4'(HOLD);
      else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
   end
   assign sync_in = (hold_r != 4'h0);
endmodule
`default_nettype wire

/* test_zoom_decimation_sync_control.sv */
// test_zoom_decimation_sync_control: self-checking bench of the zoom control top
// assumes: design, far-side model and checker compiled before this file
`timescale 1ns/1ps
`default_nettype none
module test_zoom_decimation_sync_control;
   import zds_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, slow, sync_req;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, sample_valid, sync_in, out_valid;
   logic [10:0] lo_phase, ph;
   logic        spectral_invert, settling, meas_active, trigger_allowed;
   int          error_cnt, num_checks, n;
   // ctrl word, then {continuous, block, rate log2}; extra decimation adds one at every bw, bw 0 included
   logic [38:0] rows [8] = '{{32'h00002000, 7'h20}, {32'h00001001, 7'h20},
      {32'h00003101, 7'h21}, {32'h00003002, 7'h21}, {32'h00003000, 7'h00},
      {32'h00000003, 7'h62}, {32'h00001118, 7'h78}, {32'h00002002, 7'h61}};
   zds_zoom_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sample_valid, .sync_in, .out_valid, .lo_phase,
      .spectral_invert, .settling, .meas_active, .trigger_allowed);
   zds_far_side far (.pclk, .presetn, .slow, .sync_req, .sample_valid, .sync_in);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic err);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      chk(32'({pready, pslverr}), 32'({1'b1, err}));
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge pclk);
   endtask
   task automatic pulse();
      @(posedge pclk);
      sync_req <= 1'b1;
      @(posedge pclk);
      sync_req <= 1'b0;
   endtask
   task automatic wait_on(ref logic s, input logic v);
      int k;
      k = 0;
      while (s !== v && k < 1000) begin
         k++;
         @(negedge pclk);
      end
      chk(32'(s), 32'(v));
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #100000;
      error_cnt++;
      finish_test();
   end
   initial begin
      {psel, penable, pwrite, slow, sync_req} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ZDS_OFF_CTRL, 32'h0, 0);
      chk(rd, 32'h00001000);
      apb(0, ZDS_OFF_STATUS, 32'h0, 0);
      chk(rd, 32'h000000a0);
      for (int i = 0; i < 8; i++) begin
         apb(1, ZDS_OFF_CTRL, rows[i][38:7], 0);
         apb(0, ZDS_OFF_STATUS, 32'h0, 0);
         chk(32'({rd[ZDS_ST_CONT_BIT], rd[ZDS_ST_BLK_BIT], rd[12:8]}), 32'(rows[i][6:0]));
      end
      apb(1, ZDS_OFF_CTRL, 32'h00000019, 1);
      apb(0, ZDS_OFF_CTRL, 32'h0, 0);
      chk(rd, 32'h00002002);
      apb(1, ZDS_OFF_COARSE, 32'h00000800, 1);
      apb(1, ZDS_OFF_FINE, 32'h1dcd6500, 1);
      apb(1, ZDS_OFF_FINE, 32'h1dcd64ff, 0);
      apb(1, ZDS_OFF_COARSE, 32'h000007ff, 0);
      apb(0, ZDS_OFF_COARSE, 32'h0, 0);
      chk(rd, 32'h000007ff);
      apb(1, ZDS_OFF_STATUS, 32'h0, 1);
      apb(0, 8'h14, 32'h0, 1);
      chk(rd, 32'h0);
      apb(1, ZDS_OFF_CTRL, 32'h00007000, 0);
      apb(1, ZDS_OFF_CMD, 32'h4, 0);
      cyc(3);
      chk(32'(meas_active), 32'h0);
      apb(1, ZDS_OFF_CTRL, 32'h00000002, 0);
      apb(1, ZDS_OFF_CMD, 32'h4, 0);
      wait_on(meas_active, 1'b1);
      apb(1, ZDS_OFF_CMD, 32'h1, 0);
      wait_on(meas_active, 1'b0);
      apb(0, ZDS_OFF_STATUS, 32'h0, 0);
      chk(32'({rd[7], rd[2:0]}), 32'h1);
      apb(1, ZDS_OFF_CMD, 32'h2, 0);
      apb(0, ZDS_OFF_STATUS, 32'h0, 0);
      chk(32'(rd[7]), 32'h1);
      apb(1, ZDS_OFF_CMD, 32'h1, 0);
      pulse();
      wait_on(settling, 1'b1);
      apb(0, ZDS_OFF_STATUS, 32'h0, 0);
      chk(32'({rd[7], rd[4], rd[2:0]}), 32'h1a);
      wait_on(settling, 1'b0);
      pulse();
      wait_on(trigger_allowed, 1'b1);
      @(posedge pclk);
      slow <= 1'b1;
      apb(1, ZDS_OFF_CTRL, 32'h00000104, 0);
      n = 0;
      repeat (256) begin
         @(negedge pclk);
         if (out_valid === 1'b1) n++;
      end
      chk(n, 32'h4);
      chk(32'({trigger_allowed, settling}), 32'h2);
      @(posedge pclk);
      slow <= 1'b0;
      apb(1, ZDS_OFF_FINE, 32'h0, 0);
      apb(1, ZDS_OFF_COARSE, 32'h00000200, 0);
      cyc(3);
      ph = lo_phase;
      cyc(4);
      chk(32'(lo_phase), 32'(11'(ph + 11'h400)));
      chk(32'(spectral_invert), 32'h0);
      apb(1, ZDS_OFF_COARSE, 32'h00000600, 0);
      cyc(3);
      chk(32'(spectral_invert), 32'h1);
      apb(1, ZDS_OFF_CTRL, 32'h00000504, 0);
      apb(1, ZDS_OFF_COARSE, 32'h00000100, 0);
      cyc(3);
      chk(32'(spectral_invert), 32'h1);
      apb(0, ZDS_OFF_STATUS, 32'h0, 0);
      chk(32'(rd[ZDS_ST_PEND_BIT]), 32'h1);
      pulse();
      wait_on(spectral_invert, 1'b0);
      apb(1, ZDS_OFF_COARSE, 32'h00000400, 0);
      apb(1, ZDS_OFF_CTRL, 32'h00000104, 0);
      cyc(3);
      chk(32'(spectral_invert), 32'h1);
      apb(1, ZDS_OFF_COARSE, 32'h0, 0);
      cyc(3);
      chk(32'(lo_phase), 32'h0);
      apb(1, ZDS_OFF_COARSE, 32'h00000003, 0);
      cyc(5);
      apb(1, ZDS_OFF_CTRL, 32'h00000304, 0);
      apb(1, ZDS_OFF_COARSE, 32'h0, 0);
      cyc(3);
      ph = lo_phase;
      cyc(4);
      chk(32'(lo_phase), 32'(ph));
      chk(32'(ph == 11'h0), 32'h0);
      apb(1, ZDS_OFF_COARSE, 32'h00000200, 0);
      cyc(3);
      ph = lo_phase;
      cyc(4);
      chk(32'(lo_phase), 32'(11'(ph + 11'h400)));
      // reset again in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      chk(32'({lo_phase, trigger_allowed, settling, meas_active}), 32'h0);
      presetn <= 1'b1;
      apb(0, ZDS_OFF_STATUS, 32'h0, 0);
      chk(rd, 32'h000000a0);
      finish_test();
   end
endmodule
`default_nettype wire
